/* hw/registered_buffer_parity_check.sv */
// Behaviour
// - parity input set chosen by the two configuration selects
// - parity bit compared one cycle late, or two with register-B select
// - error output stays low at least two clocks once asserted
// - consecutive errors keep error output low for the whole run
// - mismatch drives partial parity high and error low; match drives partial parity low and error high once the hold count expires
// - both chip selects high ignores that cycle's data; from the second consecutive such cycle the parity outputs hold
// - error two or more cycles before standby gives normal indication
// - error one cycle before standby stretches indication over standby
// - partial parity high on odd count of ones including parity bit
// - reset clears registers, outputs low, error output and its enable high
// - clock enable, chip select, termination always registered
`timescale 1ns/10ps
`default_nettype none

module registered_buffer_parity_check (
   input  wire logic                              i_sys_clk,
   input  wire logic                              i_nrst,
   input  wire parity_buffer_pkg::cfg_t           i_cfg,
   input  wire logic [24:0]                       i_data,
   input  wire logic                              i_parity_input_bit,
   input  wire logic                              i_chip_select_a_n,
   input  wire logic                              i_chip_select_b_n,
   input  wire logic                              i_clk_enable_in,
   input  wire logic                              i_termination_ctrl_in,
   output var  parity_buffer_pkg::ctrl_t          o_ctrl,
   output logic                                   o_partial_parity_out,
   output logic                                   o_parity_error_n,
   output logic                                   o_parity_error_oe_n
);
   import parity_buffer_pkg::*;

   // *******************************************************
   // state
   // *******************************************************
   logic        data_par;
   logic        data_par_d1;
   logic        data_par_d2;
   logic        par_q;
   logic        standby_q;
   logic [1:0]  err_cnt;
   ctrl_t       next_ctrl;
   logic        next_data_par;
   logic        next_data_par_d1;
   logic        next_data_par_d2;
   logic        next_par_q;
   logic        next_standby_q;
   logic [1:0]  next_err_cnt;
   logic        next_ppo;
   logic        next_err_n;
   logic [24:0] mask;
   logic        standby;
   logic        hold;
   logic        mismatch;

   // *******************************************************
   // combinational next values
   // *******************************************************
   always_comb begin
      unique case ({i_cfg.register_b_select, i_cfg.split_mode_select})
         2'b01:   mask = MASK_REG_A;
         2'b11:   mask = MASK_REG_B;
         default: mask = MASK_ONE_TO_ONE;
      endcase
      standby = i_chip_select_a_n & i_chip_select_b_n;
      hold    = standby & standby_q;

      next_ctrl.clk_enable    = i_clk_enable_in;
      next_ctrl.chip_select_n = i_chip_select_a_n;
      next_ctrl.termination   = i_termination_ctrl_in;

      // data of the standby cycle is dropped
      next_data_par    = standby ? data_par : ^(i_data & mask);
      next_data_par_d1 = data_par;
      next_data_par_d2 = data_par_d1;
      next_par_q       = i_parity_input_bit;
      next_standby_q   = standby;

      // align data parity to parity latency
      mismatch = (i_cfg.register_b_select ? data_par_d2 : data_par_d1)
                 ^ par_q;

      next_ppo     = o_partial_parity_out;
      next_err_n   = o_parity_error_n;
      next_err_cnt = err_cnt;
      if (!hold) begin
         next_ppo = mismatch;
         if (mismatch) begin
            next_err_n = 1'b0;
            next_err_cnt = o_parity_error_n ? (ERR_MIN_HOLD - 2'h1) : 2'h0;
         end else if (err_cnt != 2'h0) begin
            next_err_n   = 1'b0;
            next_err_cnt = err_cnt - 2'h1;
         end else begin
            next_err_n = 1'b1;
         end
      end
   end

   // *******************************************************
   // registers
   // *******************************************************
   // asynchronous clear
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_ctrl               <= '{CTRL_RESET, CTRL_RESET, CTRL_RESET};
         data_par             <= 1'b0;
         data_par_d1          <= 1'b0;
         data_par_d2          <= 1'b0;
         par_q                <= 1'b0;
         standby_q            <= 1'b0;
         err_cnt              <= 2'h0;
         o_partial_parity_out <= PPO_RESET;
         o_parity_error_n     <= ERR_N_RESET;
      end else begin
         o_ctrl               <= next_ctrl;
         data_par             <= next_data_par;
         data_par_d1          <= next_data_par_d1;
         data_par_d2          <= next_data_par_d2;
         par_q                <= next_par_q;
         standby_q            <= next_standby_q;
         err_cnt              <= next_err_cnt;
         o_partial_parity_out <= next_ppo;
         o_parity_error_n     <= next_err_n;
      end
   end

   // open-drain: enable low while pulling low
   assign o_parity_error_oe_n = o_parity_error_n;

   // *******************************************************
   // assertions
   // *******************************************************
   logic [24:0] chk_mask;
   always_comb begin
      chk_mask = MASK_ONE_TO_ONE;
      if (i_cfg.split_mode_select) begin
         chk_mask = i_cfg.register_b_select ? MASK_REG_B : MASK_REG_A;
      end
   end

   property p_err_min_two;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      $fell(o_parity_error_n) |=> !o_parity_error_n;
   endproperty
   a_err_min_two: assert property (p_err_min_two)
      else $error("error output released after one clock");

   property p_err_rise_clean;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      $rose(o_parity_error_n) |-> !o_partial_parity_out;
   endproperty
   a_err_rise_clean: assert property (p_err_rise_clean)
      else $error("error output released right after a mismatch");

   property p_err_run;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (mismatch && !hold) |=> (!o_parity_error_n && o_partial_parity_out);
   endproperty
   a_err_run: assert property (p_err_run)
      else $error("mismatch did not drive error low");

   property p_ppo_err;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      o_partial_parity_out |-> !o_parity_error_n;
   endproperty
   a_ppo_err: assert property (p_ppo_err)
      else $error("partial parity high with error output high");

   property p_standby_hold;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      (i_chip_select_a_n && i_chip_select_b_n)[*2] |=>
         ($stable(o_partial_parity_out) && $stable(o_parity_error_n));
   endproperty
   a_standby_hold: assert property (p_standby_hold)
      else $error("outputs changed during standby");

   property p_latency;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      ($past(i_nrst, 5) && !$past(standby, 1) && !$past(standby, 2)
       && !$past(standby, 3) && !$past(standby, 4) && $stable(i_cfg)
       && !i_cfg.register_b_select)
      |-> o_partial_parity_out ==
          (^($past(i_data, 3) & $past(chk_mask, 3))
           ^ $past(i_parity_input_bit, 2));
   endproperty
   a_latency: assert property (p_latency)
      else $error("partial parity not aligned to parity bit");

   property p_ctrl_pass;
      @(posedge i_sys_clk) disable iff (!i_nrst)
      ##1 $past(i_nrst) |-> o_ctrl.clk_enable == $past(i_clk_enable_in)
          && o_ctrl.termination == $past(i_termination_ctrl_in)
          && o_ctrl.chip_select_n == $past(i_chip_select_a_n);
   endproperty
   a_ctrl_pass: assert property (p_ctrl_pass)
      else $error("control bits not registered");

   property p_reset_values;
      @(posedge i_sys_clk)
      !i_nrst |-> (!o_partial_parity_out && o_parity_error_n
                   && o_ctrl == '0);
   endproperty
   a_reset_values: assert property (p_reset_values)
      else $error("outputs not at reset values");

   c_single_error: cover property (@(posedge i_sys_clk)
      disable iff (!i_nrst) $fell(o_parity_error_n) ##2 o_parity_error_n);
   c_error_run: cover property (@(posedge i_sys_clk)
      disable iff (!i_nrst) !o_parity_error_n[*4]);
   c_standby_error: cover property (@(posedge i_sys_clk)
      disable iff (!i_nrst) !o_parity_error_n && hold);
   c_reg_b: cover property (@(posedge i_sys_clk)
      disable iff (!i_nrst) i_cfg.register_b_select && mismatch);

endmodule

`default_nettype wire

/* hw/parity_buffer_pkg.sv */
package parity_buffer_pkg;

   // *******************************************************
   // configuration input set, bit 0 is data input 1
   // *******************************************************
   localparam int         DATA_W        = 25;
   localparam logic [24:0] MASK_ONE_TO_ONE = 25'h1FFFFB6;
   localparam logic [24:0] MASK_REG_A      = 25'h0003FB6;
   localparam logic [24:0] MASK_REG_B      = 25'h0001BBF;

   // *******************************************************
   // timing counts and reset values
   // *******************************************************
   localparam logic [1:0] ERR_MIN_HOLD   = 2'h2;
   localparam logic       PPO_RESET      = 1'b0;
   localparam logic       ERR_N_RESET    = 1'b1;
   localparam logic       CTRL_RESET     = 1'b0;

   typedef struct packed {
      logic clk_enable;
      logic chip_select_n;
      logic termination;
   } ctrl_t;

   typedef struct packed {
      logic register_b_select;
      logic split_mode_select;
   } cfg_t;

endpackage

/* tb/ctrl_parity_model.sv */
`timescale 1ns/10ps
`default_nettype none

module ctrl_parity_model (
   input  wire logic i_sys_clk,
   input  wire logic i_nrst,
   input  wire logic i_late,
   input  wire logic i_par,
   output logic      o_parity
);
   logic p1;
   logic p2;
   always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         p1 <= 1'b0;
         p2 <= 1'b0;
      end else begin
         p1 <= i_par;
         p2 <= p1;
      end
   end
   assign o_parity = i_late ? p2 : p1;
endmodule

`default_nettype wire

/* tb/tb_registered_buffer_parity_check.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
   error_cnt++; $display("MISMATCH t=%0t got %h exp %h", $time, a, e); \
   end end

module tb_registered_buffer_parity_check;
   import parity_buffer_pkg::*;
   logic        clk = 1'b0;
   logic        nrst = 1'b1;
   cfg_t        cfg = '0;
   logic [24:0] data = '0;
   logic        par = 1'b0;
   logic        cs_a_n = 1'b0;
   logic        cs_b_n = 1'b1;
   logic        cke = 1'b0;
   logic        odt = 1'b0;
   logic        parity;
   ctrl_t       ctrl;
   logic        partial_parity_out;
   logic        err_n;
   logic        oe_n;
   int          error_cnt = 0;
   int          total_checks = 0;
   int          cycles = 0;

   always #4 clk = ~clk;

   ctrl_parity_model i_model (.i_sys_clk(clk), .i_nrst(nrst),
      .i_late(cfg.register_b_select), .i_par(par), .o_parity(parity));

   registered_buffer_parity_check i_dut (.i_sys_clk(clk), .i_nrst(nrst),
      .i_cfg(cfg), .i_data(data), .i_parity_input_bit(parity),
      .i_chip_select_a_n(cs_a_n), .i_chip_select_b_n(cs_b_n),
      .i_clk_enable_in(cke), .i_termination_ctrl_in(odt), .o_ctrl(ctrl),
      .o_partial_parity_out(partial_parity_out), .o_parity_error_n(err_n),
      .o_parity_error_oe_n(oe_n));

   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic rst_chk();
      @(posedge clk);
      nrst <= 1'b0;
      #1 `CHK(ctrl, 3'h0)
      `CHK({partial_parity_out, err_n, oe_n}, 3'h3)
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
   endtask

   // one word with a single bit set, parity as given
   task automatic chk_bit(input cfg_t c, input int b, input logic p,
                          input logic e);
      cfg <= c;
      repeat (4) @(posedge clk);
      data <= 25'h1 << b;
      par <= p;
      @(posedge clk);
      data <= '0;
      par <= 1'b0;
      repeat (c.register_b_select ? 3 : 2) @(posedge clk);
      #1 `CHK(partial_parity_out, e)
      `CHK({err_n, oe_n}, {~e, ~e})
      @(posedge clk);
      #1 `CHK({partial_parity_out, err_n}, {1'b0, ~e})
      @(posedge clk);
      #1 `CHK(err_n, 1'b1)
   endtask

   task automatic err_run();
      int lows;
      lows = 0;
      cfg <= '0;
      repeat (4) @(posedge clk);
      data <= 25'h1000000;
      repeat (3) @(posedge clk);
      data <= '0;
      repeat (8) begin
         #1 lows += (err_n === 1'b0);
         @(posedge clk);
      end
      `CHK(lows, 3)
      data <= 25'h1000000;
      @(posedge clk);
      data <= '0;
      repeat (2) @(posedge clk);
      rst_chk();
   endtask

   task automatic standby();
      cke <= 1'b1;
      odt <= 1'b1;
      cs_a_n <= 1'b1;
      cs_b_n <= 1'b1;
      data <= 25'h1000000;
      repeat (6) begin
         @(posedge clk);
         #1 `CHK({partial_parity_out, err_n}, 2'h1)
      end
      `CHK(ctrl, 3'h7)
      cs_a_n <= 1'b0;
      cke <= 1'b0;
      data <= '0;
      @(posedge clk);
      #1 `CHK(ctrl, 3'h1)
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 1000) begin
         error_cnt++;
         complete_run();
      end
   end

   initial begin
      nrst <= 1'b0;
      rst_chk();
      chk_bit(2'h0, 24, 1'b0, 1'b1);
      chk_bit(2'h0, 6, 1'b0, 1'b0);
      chk_bit(2'h0, 0, 1'b1, 1'b1);
      chk_bit(2'h1, 13, 1'b0, 1'b1);
      chk_bit(2'h1, 14, 1'b0, 1'b0);
      chk_bit(2'h1, 24, 1'b1, 1'b1);
      chk_bit(2'h3, 12, 1'b0, 1'b1);
      chk_bit(2'h3, 10, 1'b0, 1'b0);
      chk_bit(2'h3, 0, 1'b1, 1'b0);
      chk_bit(2'h3, 13, 1'b0, 1'b0);
      err_run();
      standby();
      complete_run();
   end
endmodule

`default_nettype wire
